/* File: timer16_defines.svh */
// timer16_defines.svh: offsets, field positions, reset values and fixed tops
// assumes: included by bare name from the timer design files
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ==================================================
// register offsets on the 8-bit internal bus
`define T16_ADDR_CTRL_A   4'h0
`define T16_ADDR_CTRL_B   4'h1
`define T16_ADDR_CNT_L    4'h2
`define T16_ADDR_CNT_H    4'h3
`define T16_ADDR_CMPA_L   4'h4
`define T16_ADDR_CMPA_H   4'h5
`define T16_ADDR_CMPB_L   4'h6
`define T16_ADDR_CMPB_H   4'h7
`define T16_ADDR_CAP_L    4'h8
`define T16_ADDR_CAP_H    4'h9
`define T16_ADDR_FLAGS    4'hA

// ==================================================
// field positions
`define T16_CTRLA_MODE_A_HI 7
`define T16_CTRLA_MODE_A_LO 6
`define T16_CTRLA_MODE_B_HI 5
`define T16_CTRLA_MODE_B_LO 4
`define T16_CTRLA_WGM_HI    1
`define T16_CTRLB_CAP_EDGE  6
`define T16_CTRLB_CAP_FILT  7
`define T16_CTRLB_CAP_SRC   5
`define T16_CTRLB_WGM_HI    4
`define T16_CTRLB_RUN       0

// ==================================================
// reset values and fixed limits
`define T16_CTRL_RESET    8'h00
`define T16_WORD_RESET    16'h0000
`define T16_BOTTOM        16'h0000
`define T16_MAX           16'hFFFF
`define T16_TOP_8BIT      16'h00FF
`define T16_TOP_9BIT      16'h01FF
`define T16_TOP_10BIT     16'h03FF
`define T16_FILTER_LEN    4

`endif

/* File: timer16_pkg.sv */
// timer16_pkg.sv: types shared by the timer files
// assumes: nothing beyond the defines header
`default_nettype none
package timer16_pkg;
  typedef enum logic [1:0] {
    OUT_OFF,
    OUT_TOGGLE,
    OUT_CLEAR,
    OUT_SET
  } out_mode_type;

  typedef enum logic [1:0] {
    TOP_FIXED,
    TOP_CMPA,
    TOP_CAP,
    TOP_MAX
  } top_src_type;
endpackage
`default_nettype wire

/* File: timer16_capture.sv */
// timer16_capture.sv: capture input synchroniser, noise filter, edge detect
// assumes: pin is asynchronous; comparator input also passes the synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"

module timer16_capture (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // event sources
  input  wire logic capture_input_pin_i,
  input  wire logic comparator_i,
  // settings
  input  wire logic src_comp_i,
  input  wire logic filter_en_i,
  input  wire logic rising_i,
  // result
  output logic      event_o
);

  logic [1:0]                   sync_r, sync_nxt;
  logic [`T16_FILTER_LEN-1:0]   hist_r, hist_nxt;
  logic                         level_r, level_nxt;
  logic                         prev_r, prev_nxt;
  logic                         sel;

  // ==================================================
  // sync then filter
  always_comb begin
    sync_nxt  = {sync_r[0], src_comp_i ? comparator_i : capture_input_pin_i};
    hist_nxt  = {hist_r[`T16_FILTER_LEN-2:0], sync_r[1]};
    sel       = sync_r[1];
    // filter: level only moves after a full run of equal samples
    if (filter_en_i) begin
      if (&hist_r) begin
        sel = 1'b1;
      end else if (~|hist_r) begin
        sel = 1'b0;
      end else begin
        sel = level_r;
      end
    end
    level_nxt = sel;
    prev_nxt  = level_r;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync_r  <= 2'h0;
      hist_r  <= '0;
      level_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync_r  <= sync_nxt;
      hist_r  <= hist_nxt;
      level_r <= level_nxt;
      prev_r  <= prev_nxt;
    end
  end

  assign event_o = rising_i ? (level_r & ~prev_r) : (~level_r & prev_r);

endmodule
`default_nettype wire

/* File: timer16_core.sv */
// timer16_core.sv: 16-bit timer with two compare channels and input capture
// assumes: core bus gives one-cycle read/write strobes; reads return the next cycle
//
// How it works
// [R01] nonzero output mode routes compare output to pin
// [R02] modes: off, toggle, clear, set on match
// [R03] compare both values continuously, set match flags
// [R04] edge event copies counter into capture value unless capture is top
// [R05] top is max, fixed, compare A, or capture
// [R06] compare A top in pwm modes is double-buffered, no waveform
// [R07] bottom is zero, max is all ones
// [R08] one shared temporary high byte register
// [R09] low byte write loads full word
// [R10] low byte read latches high byte
// [R11] compare value reads bypass temporary register
// [R12] software writes high first, reads low first
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"

module timer16_core (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // internal 8-bit data bus
  input  wire logic [3:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  // pins and port direction
  input  wire logic       capture_input_pin_i,
  input  wire logic       comparator_i,
  input  wire logic       dir_a_i,
  input  wire logic       dir_b_i,
  output logic            compare_out_a_o,
  output logic            compare_out_b_o,
  output logic            override_a_o,
  output logic            override_b_o,
  output logic            drive_en_a_o,
  output logic            drive_en_b_o,
  // events
  output logic [1:0]      compare_match_flags_o,
  output logic            capture_flag_o,
  output logic            overflow_flag_o
);

  logic [7:0]  timer_control_a_r, timer_control_a_nxt;
  logic [7:0]  ctrl_b_r, ctrl_b_nxt;
  logic [15:0] counter_value_r, counter_value_nxt;
  logic [15:0] cmp_buf_r [2];
  logic [15:0] cmp_buf_nxt [2];
  logic [15:0] cmp_act_r [2];
  logic [15:0] cmp_act_nxt [2];
  logic [15:0] capture_value_r, capture_value_nxt;
  logic [7:0]  temp_hi_r, temp_hi_nxt;
  logic [1:0]  out_r, out_nxt;
  logic [1:0]  match_flag_r, match_flag_nxt;
  logic        cap_flag_r, cap_flag_nxt;
  logic        ovf_flag_r, ovf_flag_nxt;
  logic [3:0]  waveform_mode_select;
  logic [15:0] top;
  logic        at_top;
  logic        pwm;
  logic        cap_event;
  logic [1:0]  hit;
  logic [7:0]  rdata_nxt;
  logic [1:0]  mode [2];
  timer16_pkg::top_src_type top_src;

  assign waveform_mode_select = {ctrl_b_r[`T16_CTRLB_WGM_HI:3],
                                 timer_control_a_r[`T16_CTRLA_WGM_HI:0]};
  assign mode[0] = timer_control_a_r[`T16_CTRLA_MODE_A_HI:`T16_CTRLA_MODE_A_LO];
  assign mode[1] = timer_control_a_r[`T16_CTRLA_MODE_B_HI:`T16_CTRLA_MODE_B_LO];

  // ==================================================
  // capture front end
  timer16_capture u_capture (
    .clock_i             (clock_i),
    .rst_i               (rst_i),
    .capture_input_pin_i (capture_input_pin_i),
    .comparator_i        (comparator_i),
    .src_comp_i          (ctrl_b_r[`T16_CTRLB_CAP_SRC]),
    .filter_en_i         (ctrl_b_r[`T16_CTRLB_CAP_FILT]),
    .rising_i            (ctrl_b_r[`T16_CTRLB_CAP_EDGE]),
    .event_o             (cap_event)
  );

  // ==================================================
  // top selection
  // [R05] mode picks top
  always_comb begin
    top_src = timer16_pkg::TOP_MAX;
    top     = `T16_MAX;
    pwm     = 1'b0;
    case (waveform_mode_select)
      4'h1, 4'h5: begin
        top_src = timer16_pkg::TOP_FIXED;
        top     = `T16_TOP_8BIT;
        pwm     = 1'b1;
      end
      4'h2, 4'h6: begin
        top_src = timer16_pkg::TOP_FIXED;
        top     = `T16_TOP_9BIT;
        pwm     = 1'b1;
      end
      4'h3, 4'h7: begin
        top_src = timer16_pkg::TOP_FIXED;
        top     = `T16_TOP_10BIT;
        pwm     = 1'b1;
      end
      4'h4: begin
        top_src = timer16_pkg::TOP_CMPA;
        top     = cmp_act_r[0];
      end
      4'h9, 4'hB, 4'hF: begin
        top_src = timer16_pkg::TOP_CMPA;
        top     = cmp_act_r[0];
        pwm     = 1'b1;
      end
      4'hC: begin
        top_src = timer16_pkg::TOP_CAP;
        top     = capture_value_r;
      end
      4'h8, 4'hA, 4'hE: begin
        top_src = timer16_pkg::TOP_CAP;
        top     = capture_value_r;
        pwm     = 1'b1;
      end
      default: begin
        top_src = timer16_pkg::TOP_MAX;
        top     = `T16_MAX;
      end
    endcase
  end

  // [R07] max wraps to bottom
  assign at_top = (counter_value_r == top) || (counter_value_r == `T16_MAX);

  // ==================================================
  // compare channels
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // [R03] continuous compare
      assign hit[ch] = ctrl_b_r[`T16_CTRLB_RUN] && (counter_value_r == cmp_act_r[ch]);

      // [R02] output mode decode
      always_comb begin
        out_nxt[ch] = out_r[ch];
        if (hit[ch] && !(pwm && ch == 0 && top_src == timer16_pkg::TOP_CMPA)) begin
          case (timer16_pkg::out_mode_type'(mode[ch]))
            timer16_pkg::OUT_TOGGLE: out_nxt[ch] = ~out_r[ch];
            timer16_pkg::OUT_CLEAR:  out_nxt[ch] = 1'b0;
            timer16_pkg::OUT_SET:    out_nxt[ch] = 1'b1;
            default:                 out_nxt[ch] = out_r[ch];
          endcase
        end
      end
    end
  endgenerate

  // [R01] pin override and driver enable
  assign override_a_o    = |mode[0];
  assign override_b_o    = |mode[1];
  assign drive_en_a_o    = override_a_o & dir_a_i;
  assign drive_en_b_o    = override_b_o & dir_b_i;
  assign compare_out_a_o = out_r[0];
  assign compare_out_b_o = out_r[1];

  // ==================================================
  // bus, counter and register updates
  always_comb begin
    timer_control_a_nxt = timer_control_a_r;
    ctrl_b_nxt          = ctrl_b_r;
    counter_value_nxt   = counter_value_r;
    capture_value_nxt   = capture_value_r;
    temp_hi_nxt         = temp_hi_r;
    cmp_buf_nxt         = cmp_buf_r;
    cmp_act_nxt         = cmp_act_r;
    match_flag_nxt      = match_flag_r | hit;
    cap_flag_nxt        = cap_flag_r | cap_event;
    ovf_flag_nxt        = ovf_flag_r;
    rdata_nxt           = 8'h00;

    if (ctrl_b_r[`T16_CTRLB_RUN]) begin
      counter_value_nxt = at_top ? `T16_BOTTOM : counter_value_r + 16'h0001;
      if (at_top) begin
        ovf_flag_nxt = 1'b1;
      end
    end

    // [R06] buffered values move at top in pwm modes
    for (int i = 0; i < 2; i++) begin
      if (!pwm || (ctrl_b_r[`T16_CTRLB_RUN] && at_top)) begin
        cmp_act_nxt[i] = cmp_buf_r[i];
      end
    end

    // [R04] capture on edge event
    if (cap_event && top_src != timer16_pkg::TOP_CAP) begin
      capture_value_nxt = counter_value_r;
    end

    if (wr_i) begin
      case (addr_i)
        `T16_ADDR_CTRL_A: timer_control_a_nxt = wdata_i;
        `T16_ADDR_CTRL_B: ctrl_b_nxt          = wdata_i;
        // [R08] shared temporary high byte
        `T16_ADDR_CNT_H, `T16_ADDR_CMPA_H,
        `T16_ADDR_CMPB_H, `T16_ADDR_CAP_H: temp_hi_nxt = wdata_i;
        // [R09] full word load on low write
        `T16_ADDR_CNT_L:  counter_value_nxt = {temp_hi_r, wdata_i};
        `T16_ADDR_CMPA_L: cmp_buf_nxt[0]    = {temp_hi_r, wdata_i};
        `T16_ADDR_CMPB_L: cmp_buf_nxt[1]    = {temp_hi_r, wdata_i};
        `T16_ADDR_CAP_L:  capture_value_nxt = {temp_hi_r, wdata_i};
        // write one clears, a same-cycle event still wins
        `T16_ADDR_FLAGS: begin
          match_flag_nxt = (match_flag_r & ~wdata_i[1:0]) | hit;
          cap_flag_nxt   = (cap_flag_r & ~wdata_i[2]) | cap_event;
          ovf_flag_nxt   = (ovf_flag_r & ~wdata_i[3]) |
                           (ctrl_b_r[`T16_CTRLB_RUN] & at_top);
        end
        default: ;
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        `T16_ADDR_CTRL_A: rdata_nxt = timer_control_a_r;
        `T16_ADDR_CTRL_B: rdata_nxt = ctrl_b_r;
        // [R10] low read latches high byte
        `T16_ADDR_CNT_L: begin
          rdata_nxt   = counter_value_r[7:0];
          temp_hi_nxt = counter_value_r[15:8];
        end
        `T16_ADDR_CAP_L: begin
          rdata_nxt   = capture_value_r[7:0];
          temp_hi_nxt = capture_value_r[15:8];
        end
        `T16_ADDR_CNT_H, `T16_ADDR_CAP_H: rdata_nxt = temp_hi_r;
        // [R11] direct compare reads
        `T16_ADDR_CMPA_L: rdata_nxt = cmp_buf_r[0][7:0];
        `T16_ADDR_CMPA_H: rdata_nxt = cmp_buf_r[0][15:8];
        `T16_ADDR_CMPB_L: rdata_nxt = cmp_buf_r[1][7:0];
        `T16_ADDR_CMPB_H: rdata_nxt = cmp_buf_r[1][15:8];
        `T16_ADDR_FLAGS:  rdata_nxt = {4'h0, ovf_flag_r, cap_flag_r, match_flag_r};
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      timer_control_a_r <= `T16_CTRL_RESET;
      ctrl_b_r          <= `T16_CTRL_RESET;
      counter_value_r   <= `T16_WORD_RESET;
      capture_value_r   <= `T16_WORD_RESET;
      temp_hi_r         <= 8'h00;
      cmp_buf_r[0]      <= `T16_WORD_RESET;
      cmp_buf_r[1]      <= `T16_WORD_RESET;
      cmp_act_r[0]      <= `T16_WORD_RESET;
      cmp_act_r[1]      <= `T16_WORD_RESET;
      out_r             <= 2'h0;
      match_flag_r      <= 2'h0;
      cap_flag_r        <= 1'b0;
      ovf_flag_r        <= 1'b0;
      rdata_o           <= 8'h00;
    end else begin
      timer_control_a_r <= timer_control_a_nxt;
      ctrl_b_r          <= ctrl_b_nxt;
      counter_value_r   <= counter_value_nxt;
      capture_value_r   <= capture_value_nxt;
      temp_hi_r         <= temp_hi_nxt;
      cmp_buf_r         <= cmp_buf_nxt;
      cmp_act_r         <= cmp_act_nxt;
      out_r             <= out_nxt;
      match_flag_r      <= match_flag_nxt;
      cap_flag_r        <= cap_flag_nxt;
      ovf_flag_r        <= ovf_flag_nxt;
      rdata_o           <= rdata_nxt;
    end
  end

  assign compare_match_flags_o = match_flag_r;
  assign capture_flag_o        = cap_flag_r;
  assign overflow_flag_o       = ovf_flag_r;

endmodule
`default_nettype wire

/* File: timer16_core_monitor.sv */
// timer16_core_monitor.sv: port assertions for timer16_core
// assumes: bound into every timer16_core; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module timer16_core_monitor (
  // watched ports
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [3:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       dir_a_i,
  input wire logic       override_a_o,
  input wire logic       drive_en_a_o,
  input wire logic [1:0] compare_match_flags_o,
  input wire logic       capture_flag_o,
  input wire logic       overflow_flag_o
);
  // ========
  // channel a mode shadow, followed from bus writes
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic       fclr;
  assign fclr = wr_i && addr_i == 4'hA;
  always_comb begin
    mode_nxt = mode_r;
    if (wr_i && addr_i == 4'h0) mode_nxt = wdata_i[7:6];
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) mode_r <= 2'b00;
    else mode_r <= mode_nxt;
  end
  // ========
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_ovr_a; override_a_o == (mode_r != 2'b00); endproperty
  a_ovr_a: assert property (p_ovr_a) else $error("override a wrong");
  property p_drv_a; drive_en_a_o == (override_a_o && dir_a_i); endproperty
  a_drv_a: assert property (p_drv_a) else $error("drive a wrong");
  property p_hold_a; compare_match_flags_o[0] && !(fclr && wdata_i[0]) |=> compare_match_flags_o[0]; endproperty
  a_hold_a: assert property (p_hold_a) else $error("match a lost");
  property p_hold_b; compare_match_flags_o[1] && !(fclr && wdata_i[1]) |=> compare_match_flags_o[1]; endproperty
  a_hold_b: assert property (p_hold_b) else $error("match b lost");
  property p_hold_c; capture_flag_o && !(fclr && wdata_i[2]) |=> capture_flag_o; endproperty
  a_hold_c: assert property (p_hold_c) else $error("capture flag lost");
  property p_hold_o; overflow_flag_o && !(fclr && wdata_i[3]) |=> overflow_flag_o; endproperty
  a_hold_o: assert property (p_hold_o) else $error("wrap flag lost");
  property p_rd_flags;
    rd_i && !wr_i && addr_i == 4'hA |=> rdata_o == {4'h0, $past(overflow_flag_o),
      $past(capture_flag_o), $past(compare_match_flags_o)};
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");
  property p_unmapped; rd_i && addr_i > 4'hA |=> rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_flag_read: cover property (rd_i && addr_i == 4'hA);
  c_capture: cover property ($rose(capture_flag_o));
  c_drive: cover property (drive_en_a_o && mode_r == 2'b10);
endmodule
bind timer16_core timer16_core_monitor timer16_core_monitor_i (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .dir_a_i(dir_a_i), .override_a_o(override_a_o),
  .drive_en_a_o(drive_en_a_o), .compare_match_flags_o(compare_match_flags_o),
  .capture_flag_o(capture_flag_o), .overflow_flag_o(overflow_flag_o));
`default_nettype wire

/* File: core_bus_model.sv */
// core_bus_model.sv: processor side of the timer's 8-bit bus
// assumes: strobes taken at rising clock_i, read data the cycle after
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
  // clock and read data
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  // requests
  output logic      [3:0] addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] wdata_o
);
  initial begin
    addr_o  = 4'hF;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    // released data shows the inverse, never a stale copy
    wdata_o <= ~d;
    #1;
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// tb.sv: self-checking bench for timer16_core
// assumes: core_bus_model drives the bus, the monitor is bound in
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic            clock_i = 1'b0;
  logic            rst_i   = 1'b1;
  logic            dir_a   = 1'b0;
  logic            dir_b   = 1'b0;
  logic            pin     = 1'b0;
  logic            comp    = 1'b0;
  wire logic [3:0] addr;
  wire logic [7:0] wd, rdat;
  wire logic [1:0] flags;
  wire logic       wr, rd, oa, ob, va, vb, da, db, capf, ovf;
  int              err_total = 0;
  int              tests_run = 0;
  logic     [15:0] v;
  localparam logic [7:0]  ca [6] = '{8'h01, 8'h02, 8'h03, 8'h41, 8'h00, 8'h00};
  localparam logic [7:0]  cb [6] = '{8'h01, 8'h01, 8'h01, 8'h11, 8'h09, 8'h19};
  localparam logic [15:0] top [6] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0040, 16'h0040,
                                      16'h0030};
  always #20 clock_i = ~clock_i;
  core_bus_model core_bus_model_i (.clock_i(clock_i), .rdata_i(rdat), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .wdata_o(wd));
  timer16_core timer16_core_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr),
    .wr_i(wr), .rd_i(rd), .wdata_i(wd), .rdata_o(rdat), .capture_input_pin_i(pin),
    .comparator_i(comp), .dir_a_i(dir_a), .dir_b_i(dir_b), .compare_out_a_o(oa),
    .compare_out_b_o(ob), .override_a_o(va), .override_b_o(vb), .drive_en_a_o(da),
    .drive_en_b_o(db), .compare_match_flags_o(flags), .capture_flag_o(capf),
    .overflow_flag_o(ovf));
  // ========
  // checks and bus helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input logic [15:0] lo, hi, g);
    tests_run++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_total++;
      $display("ERROR %s expected %h to %h seen %h", n, lo, hi, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic w8(input logic [3:0] a, input logic [7:0] d);
    core_bus_model_i.wr8(a, d);
  endtask
  task automatic r8(input logic [3:0] a, output logic [15:0] d);
    logic [7:0] b;
    core_bus_model_i.rd8(a, b);
    d = {8'h00, b};
  endtask
  task automatic w16(input logic [3:0] a, input logic [15:0] d);
    w8(a + 4'h1, d[15:8]);
    w8(a, d[7:0]);
  endtask
  task automatic r16(input logic [3:0] a, output logic [15:0] d);
    logic [15:0] lo, hi;
    r8(a, lo);
    r8(a + 4'h1, hi);
    d = {hi[7:0], lo[7:0]};
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // tests need about 13700 cycles; this leaves wide margin
    wt(40000);
    err_total++;
    tally_and_finish();
  end
  // ========
  // sequence
  initial begin
    wt(10);
    rst_i <= 1'b0;
    r8(4'h0, v);
    chk("ctrl_a_reset", 16'h0000, v);
    w8(4'h0, 8'hF3);
    r8(4'h0, v);
    chk("ctrl_a_rw", 16'h00F3, v);
    w8(4'h0, 8'h00);
    r8(4'hF, v);
    chk("unmapped", 16'h0000, v);
    w16(4'h4, 16'h1234);
    w16(4'h6, 16'hABCD);
    w8(4'h3, 8'h9A);
    r16(4'h4, v);
    chk("cmp_a", 16'h1234, v);
    r16(4'h6, v);
    chk("cmp_b", 16'hABCD, v);
    w8(4'h2, 8'hBC);
    r16(4'h2, v);
    chk("cnt_word", 16'h9ABC, v);
    // high byte must come from the low-read instant, not later
    w16(4'h2, 16'h00F0);
    w8(4'h1, 8'h01);
    r8(4'h2, v);
    chk_rng("run_lo", 16'h00F0, 16'h00FF, v);
    wt(30);
    r8(4'h3, v);
    w8(4'h1, 8'h00);
    chk("run_hi", 16'h0000, v);
    w16(4'h4, 16'h0010);
    w16(4'h6, 16'h0020);
    dir_a <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      dir_b <= (i == 1);
      w8(4'h0, i ? 8'h90 : 8'h70);
      chk("ovr_drive", i ? 16'h000F : 16'h000E, {12'h000, va, vb, da, db});
      w16(4'h2, 16'h0000);
      w8(4'h1, 8'h01);
      wt(50);
      w8(4'h1, 8'h00);
      chk("flags", 16'h0003, {14'h0000, flags});
      chk("outs", i ? 16'h0000 : 16'h0003, {14'h0000, oa, ob});
      w8(4'hA, 8'h0F);
      r8(4'hA, v);
      chk("flags_clr", 16'h0000, v);
    end
    w8(4'h0, 8'h00);
    chk("ovr_off", 16'h0000, {12'h000, va, vb, da, db});
    w16(4'h4, 16'h0040);
    w16(4'h8, 16'h0030);
    for (int i = 0; i < 6; i++) begin
      w8(4'hA, 8'h0F);
      w16(4'h2, 16'h0000);
      w8(4'h0, ca[i]);
      w8(4'h1, cb[i]);
      wt(2200);
      w8(4'h1, 8'h00);
      r16(4'h2, v);
      chk_rng("top", 16'h0000, top[i], v);
      chk("wrap", 16'h0001, {15'h0000, ovf});
    end
    chk("pwm_top_a", 16'h0000, {15'h0000, oa});
    // exactly one match at a compare A top: flag set, level held
    w8(4'hA, 8'h0F);
    w16(4'h2, 16'h003E);
    w8(4'h0, 8'h41);
    w8(4'h1, 8'h11);
    wt(4);
    w8(4'h1, 8'h00);
    chk("pwm_top_once", 16'h0002, {14'h0000, flags[0], oa});
    // capture register as top must survive an edge
    w8(4'h0, 8'h00);
    w8(4'h1, 8'h19);
    pin <= 1'b1;
    wt(12);
    pin <= 1'b0;
    wt(4);
    w8(4'h1, 8'h00);
    r16(4'h8, v);
    chk("cap_top_kept", 16'h0030, v);
    for (int i = 0; i < 2; i++) begin
      w8(4'hA, 8'h0F);
      w16(4'h2, 16'h0000);
      w8(4'h1, i ? 8'h61 : 8'h41);
      wt(20);
      if (i) comp <= 1'b1;
      else pin <= 1'b1;
      wt(12);
      chk("cap_flag", 16'h0001, {15'h0000, capf});
      r16(4'h8, v);
      chk_rng("cap_val", 16'h0014, 16'h0028, v);
      pin <= 1'b0;
      comp <= 1'b0;
    end
    // a one-cycle spike must not pass the filter
    w8(4'hA, 8'h0F);
    w8(4'h1, 8'hC1);
    wt(8);
    pin <= 1'b1;
    wt(1);
    pin <= 1'b0;
    wt(20);
    chk("cap_spike", 16'h0000, {15'h0000, capf});
    // a steady level must still pass the filter
    pin <= 1'b1;
    wt(12);
    chk("cap_filt", 16'h0001, {15'h0000, capf});
    pin <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
